// >>> rtl/decode_pkg.sv
// constants, field layouts and carrier types for the instruction decode and timing block
package decode_pkg;

  // ----------------------------------------------------------------
  // word and datapath widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 15;
  localparam int PC_W   = 13;
  localparam int KL_W   = 10;                  // jump and call address field
  localparam int TAE_BIT = 14;                 // touch environment select in config word two
  localparam int ID_W    = 6;                  // customer identification field width

  // ----------------------------------------------------------------
  // timing: oscillator periods in one instruction cycle
  // ----------------------------------------------------------------
  localparam int OSC_PER_ICYCLE = 2;

  // ----------------------------------------------------------------
  // register map, byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_ACC    = 12'h008;
  localparam logic [11:0] OFS_PC     = 12'h00c;
  localparam logic [11:0] OFS_CFG2   = 12'h010;
  localparam logic [11:0] OFS_CFG3   = 12'h014;
  localparam logic [11:0] OFS_CYCLES = 12'h018;
  localparam logic [11:0] OFS_LAST   = 12'h01c;
  localparam logic [11:0] OFS_REGS   = 12'h100;

  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_WAKE_BIT = 1;

  // ----------------------------------------------------------------
  // reset values of the factory words
  // ----------------------------------------------------------------
  localparam logic [14:0] CFG2_RESET = 15'h3f7f;   // type B, bits 14 and 7 low, rest high
  localparam logic [14:0] CFG3_UPPER = 15'h7fc0;   // unused upper bits high

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0]  PC_REG    = 8'h02;       // program_counter_register index
  localparam logic [14:0] OP_DAA    = 15'h0001;    // decimal_adjust_op
  localparam logic [14:0] OP_SLEEP  = 15'h0003;    // enter_sleep_op
  localparam logic [14:0] OP_WATCHDOG_CLEAR_OP   = 15'h0004;    // watchdog_clear_op
  localparam logic [14:0] OP_ENI    = 15'h0010;    // interrupt_enable_op
  localparam logic [14:0] OP_INTERRUPT_DISABLE_OP   = 15'h0011;    // interrupt_disable_op
  localparam logic [14:0] OP_RET    = 15'h0012;
  localparam logic [14:0] OP_INTERRUPT_RETURN_OP   = 15'h0013;    // interrupt_return_op
  localparam logic [6:0]  MJ_DECREMENT_TO_ACC_SKIP_OP   = 7'h16;       // decrement_to_acc_skip_op
  localparam logic [6:0]  MJ_DJZ    = 7'h17;       // decrement_skip_op

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0]      major;
    logic [7:0]      reg_sel;
    logic [2:0]      bit_sel;
    logic [7:0]      lit8;
    logic [KL_W-1:0] lit10;
  } fields_t;

  typedef struct packed {
    logic [7:0]      res;
    logic            wr_acc, wr_reg, wr_z, wr_cd, c, dc;
    logic            skip, jump, push, pop, to_long, long_call;
    logic            interrupt_enable_op, interrupt_disable_op, slp, watchdog_clear_op;
    logic [PC_W-1:0] target;
  } exec_t;

  function automatic fields_t split_word(input logic [WORD_W-1:0] w);
    fields_t r;
    r.major   = w[14:8];
    r.reg_sel = w[7:0];
    r.bit_sel = w[10:8];
    r.lit8    = w[7:0];
    r.lit10   = w[KL_W-1:0];
    return r;
  endfunction : split_word

endpackage : decode_pkg

// >>> rtl/instruction_decode_timing.sv
// instruction decoder, cycle timing and factory word holder of the 8-bit core
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module instruction_decode_timing
  import decode_pkg::*;
#(
  parameter int              REG_DEPTH   = 32,
  parameter int              STACK_DEPTH = 8,
  parameter logic [ID_W-1:0] CUST_ID     = 6'h00   // arbitrary value
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [PC_W-1:0]   fetch_addr,
  input  wire logic              fetch_valid,
  input  wire logic [WORD_W-1:0] fetch_word,
  output logic                   fetch_ready,
  output logic                   sleep_pulse,
  output logic                   wdt_clear_pulse,
  output logic                   touch_env_select,
  output logic      [ID_W-1:0]   customer_ident_field
);

  localparam int IDX_W = $clog2(REG_DEPTH);
  localparam int SP_W  = $clog2(STACK_DEPTH);

  typedef enum logic [1:0] {ST_EXEC, ST_FLUSH, ST_LONG} state_t;

  state_t          state_q;
  logic [1:0]      ph_q;
  logic            run_q, sleep_q, to_q, pd_q, int_en_q, flush_adv_q;
  logic            z_q, c_q, dc_q;
  logic [7:0]      acc_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [SP_W-1:0] sp_q;
  logic [7:0]      regs_q [REG_DEPTH];
  logic [14:0]     cfg2_q, cfg3_q;
  logic [31:0]     cycles_q;
  logic [1:0]      last_len_q;
  logic [31:0]     prdata_q;
  logic            sleep_pulse_q, wdt_pulse_q;

  // ----------------------------------------------------------------
  // fetch and operand selection
  // ----------------------------------------------------------------
  fields_t         f;
  logic            last_ph, take, exec_go, apb_wr, reg_hit, ph_run;
  logic [IDX_W-1:0] ridx, apb_idx;
  logic [7:0]      rval, opnd, bmask;
  logic [PC_W-1:0] top;
  exec_t           ex;

  assign f        = split_word(fetch_word);
  assign ridx     = f.reg_sel[IDX_W-1:0];                           // upper index bits mirror
  assign ph_run   = run_q & ~sleep_q;
  assign last_ph  = ph_q == 2'(OSC_PER_ICYCLE - 1);
  // no word is taken in the dead second cycle of a flush
  assign fetch_ready = ph_run & last_ph & (state_q != ST_FLUSH);
  assign take     = fetch_ready & fetch_valid;
  assign exec_go  = take & (state_q == ST_EXEC);
  assign fetch_addr = pc_q;
  // one read path for i/o and general registers alike
  assign rval     = (f.reg_sel == PC_REG) ? pc_q[7:0] : regs_q[ridx];
  assign opnd     = fetch_word[14] ? f.lit8 : rval;
  assign bmask    = 8'h01 << f.bit_sel;
  assign top      = stack_q[sp_q - SP_W'(1)];

  // ----------------------------------------------------------------
  // decode and execute, combinational
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0] sub_s, add_s;
    logic [4:0] add_h;
    logic [8:0] daa_s;
    sub_s = {1'b0, opnd} - {1'b0, acc_q};
    add_s = {1'b0, acc_q} + {1'b0, opnd};
    add_h = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]};
    daa_s = {1'b0, acc_q};
    ex    = '0;
    ex.c  = c_q;
    ex.dc = dc_q;
    if (fetch_word[14:13] == 2'b00 && fetch_word[12:10] != 3'b000) begin
      // paired forms: bit 8 low writes A, high writes R
      ex.wr_reg = fetch_word[8];
      ex.wr_acc = ~fetch_word[8];
      ex.wr_z   = 1'b1;
      unique case (fetch_word[12:9])
        4'h2: begin ex.res = sub_s[7:0]; ex.wr_cd = 1'b1; ex.c = ~sub_s[8];
                    ex.dc = opnd[3:0] >= acc_q[3:0]; end
        4'h3: ex.res = rval - 8'h01;
        4'h4: ex.res = acc_q | rval;
        4'h5: ex.res = acc_q & rval;
        4'h6: ex.res = acc_q ^ rval;
        4'h7: begin ex.res = add_s[7:0]; ex.wr_cd = 1'b1; ex.c = add_s[8]; ex.dc = add_h[4]; end
        4'h8: ex.res = rval;
        4'h9: ex.res = ~rval;
        4'ha: ex.res = rval + 8'h01;
        4'hb: begin ex.res = rval - 8'h01; ex.wr_z = 1'b0; ex.skip = ex.res == 8'h00; end
        4'hc: begin ex.res = {c_q, rval[7:1]}; ex.wr_z = 1'b0; ex.wr_cd = 1'b1; ex.c = rval[0]; end
        4'hd: begin ex.res = {rval[6:0], c_q}; ex.wr_z = 1'b0; ex.wr_cd = 1'b1; ex.c = rval[7]; end
        4'he: begin ex.res = {rval[3:0], rval[7:4]}; ex.wr_z = 1'b0; end
        4'hf: begin ex.res = rval + 8'h01; ex.wr_z = 1'b0; ex.skip = ex.res == 8'h00; end
        default: ex.wr_z = 1'b0;
      endcase
    end else begin
      casez (f.major)
        7'h00: begin
          ex.slp  = fetch_word == OP_SLEEP;
          ex.watchdog_clear_op = fetch_word == OP_SLEEP || fetch_word == OP_WATCHDOG_CLEAR_OP;
          ex.interrupt_enable_op  = fetch_word == OP_ENI || fetch_word == OP_INTERRUPT_RETURN_OP;
          ex.interrupt_disable_op = fetch_word == OP_INTERRUPT_DISABLE_OP;
          ex.pop  = fetch_word == OP_RET || fetch_word == OP_INTERRUPT_RETURN_OP;
          if (fetch_word == OP_DAA) begin
            if (acc_q[3:0] > 4'h9 || dc_q) daa_s = daa_s + 9'h006;
            if (daa_s[7:4] > 4'h9 || c_q || daa_s[8]) daa_s = daa_s + 9'h060;
            ex.res = daa_s[7:0]; ex.wr_acc = 1'b1; ex.wr_cd = 1'b1; ex.c = daa_s[8];
          end
        end
        7'h01: begin ex.res = acc_q; ex.wr_reg = 1'b1; end
        7'h02: begin ex.wr_acc = 1'b1; ex.wr_z = 1'b1; end
        7'h03: begin ex.wr_reg = 1'b1; ex.wr_z = 1'b1; end
        7'b010_????: begin
          ex.res    = fetch_word[11] ? (rval | bmask) : (rval & ~bmask);
          ex.wr_reg = 1'b1;
        end
        7'b011_????: ex.skip = ((rval & bmask) != 8'h00) == fetch_word[11];
        7'b10?_????: begin
          ex.jump   = 1'b1;
          ex.push   = ~fetch_word[12];
          ex.target = {pc_q[PC_W-1:KL_W], f.lit10};
        end
        7'h60: begin ex.res = f.lit8; ex.wr_acc = 1'b1; end
        7'h64: begin ex.res = acc_q | f.lit8; ex.wr_acc = 1'b1; ex.wr_z = 1'b1; end
        7'h68: begin ex.res = acc_q & f.lit8; ex.wr_acc = 1'b1; ex.wr_z = 1'b1; end
        7'h6c: begin ex.res = acc_q ^ f.lit8; ex.wr_acc = 1'b1; ex.wr_z = 1'b1; end
        7'h70: begin ex.res = f.lit8; ex.wr_acc = 1'b1; ex.pop = 1'b1; end
        7'h74: begin ex.res = sub_s[7:0]; ex.wr_acc = 1'b1; ex.wr_z = 1'b1; ex.wr_cd = 1'b1;
                     ex.c = ~sub_s[8]; ex.dc = opnd[3:0] >= acc_q[3:0]; end
        7'h7c: begin ex.res = add_s[7:0]; ex.wr_acc = 1'b1; ex.wr_z = 1'b1; ex.wr_cd = 1'b1;
                     ex.c = add_s[8]; ex.dc = add_h[4]; end
        7'h7a: begin
          // bit 7 marks the two-word forms, bit 6 tells the jump from the call
          ex.to_long   = fetch_word[7];
          ex.long_call = ex.to_long & ~fetch_word[6];
        end
        default: ;                                                   // bank and table ops idle
      endcase
    end
    if (ex.pop) begin
      ex.jump   = 1'b1;
      ex.target = top;
    end
    // a result landing in the counter register is a branch
    if (ex.wr_reg && f.reg_sel == PC_REG) begin
      ex.jump   = 1'b1;
      ex.target = {pc_q[PC_W-1:8], ex.res};
    end
  end

  // ----------------------------------------------------------------
  // sequencing: phase, state, counter, stack
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= '0;
    end else if (!ph_run || last_ph) begin
      ph_q <= '0;
    end else begin
      ph_q <= ph_q + 2'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= ST_EXEC;
      pc_q        <= '0;
      sp_q        <= '0;
      flush_adv_q <= 1'b0;
      last_len_q  <= '0;
      cycles_q    <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) stack_q[i] <= '0;
    end else if (ph_run && last_ph) begin
      unique case (state_q)
        ST_EXEC: if (fetch_valid) begin
          cycles_q   <= cycles_q + 32'd1;
          last_len_q <= (ex.jump || ex.skip || ex.to_long) ? 2'd2 : 2'd1;
          pc_q       <= ex.jump ? ex.target : pc_q + PC_W'(1);
          if (ex.push) begin
            stack_q[sp_q] <= pc_q + PC_W'(1);
            sp_q          <= sp_q + SP_W'(1);
          end
          if (ex.pop) sp_q <= sp_q - SP_W'(1);
          // a long call reuses this flag to push its return address in the long state
          flush_adv_q <= ex.skip | ex.long_call;
          state_q     <= ex.to_long ? ST_LONG : (ex.jump || ex.skip) ? ST_FLUSH : ST_EXEC;
        end
        ST_FLUSH: begin
          // dead cycle: no word is taken; the counter steps past a skipped word and holds after a jump
          cycles_q <= cycles_q + 32'd1;
          pc_q     <= pc_q + PC_W'(flush_adv_q);
          state_q  <= ST_EXEC;
        end
        ST_LONG: if (fetch_valid) begin
          cycles_q <= cycles_q + 32'd1;
          pc_q     <= fetch_word[PC_W-1:0];
          if (flush_adv_q) begin
            stack_q[sp_q] <= pc_q + PC_W'(1);
            sp_q          <= sp_q + SP_W'(1);
          end
          state_q <= ST_EXEC;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // accumulator and flags, only in an executing cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q    <= '0;
      z_q      <= 1'b0;
      c_q      <= 1'b0;
      dc_q     <= 1'b0;
      int_en_q <= 1'b0;
    end else if (exec_go) begin
      if (ex.wr_acc) acc_q <= ex.res;
      if (ex.wr_z)   z_q   <= ex.res == 8'h00;
      if (ex.wr_cd) begin
        c_q  <= ex.c;
        dc_q <= ex.dc;
      end
      if (ex.interrupt_enable_op)  int_en_q <= 1'b1;
      if (ex.interrupt_disable_op) int_en_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register file; the core wins over a bus write in the same cycle
  // ----------------------------------------------------------------
  assign apb_wr  = psel & penable & pwrite;
  assign reg_hit = paddr >= OFS_REGS && paddr < OFS_REGS + 12'(4 * REG_DEPTH);
  assign apb_idx = IDX_W'((paddr - OFS_REGS) >> 2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < REG_DEPTH; i++) regs_q[i] <= '0;
    end else if (exec_go && ex.wr_reg && f.reg_sel != PC_REG) begin
      regs_q[ridx] <= ex.res;
    end else if (apb_wr && reg_hit) begin
      regs_q[apb_idx] <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // control, sleep and power status, factory words
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q         <= 1'b0;
      sleep_q       <= 1'b0;
      to_q          <= 1'b1;
      pd_q          <= 1'b1;
      sleep_pulse_q <= 1'b0;
      wdt_pulse_q   <= 1'b0;
      cfg2_q        <= CFG2_RESET;
      cfg3_q        <= CFG3_UPPER | {9'h000, CUST_ID};
    end else begin
      sleep_pulse_q <= exec_go & ex.slp;
      wdt_pulse_q   <= exec_go & ex.watchdog_clear_op;
      if (exec_go && ex.watchdog_clear_op) begin
        to_q <= 1'b1;
        pd_q <= ~ex.slp;
      end
      // sleep set beats a wake written in the same cycle
      if (exec_go && ex.slp) sleep_q <= 1'b1;
      else if (apb_wr && paddr == OFS_CTRL && pwdata[CTRL_WAKE_BIT]) sleep_q <= 1'b0;
      if (apb_wr && paddr == OFS_CTRL) run_q <= pwdata[CTRL_RUN_BIT];
      if (apb_wr && paddr == OFS_CFG2) cfg2_q <= pwdata[14:0];
      if (apb_wr && paddr == OFS_CFG3) cfg3_q <= pwdata[14:0];
    end
  end

  assign touch_env_select     = cfg2_q[TAE_BIT];
  assign customer_ident_field = cfg3_q[ID_W-1:0];
  assign sleep_pulse          = sleep_pulse_q;
  assign wdt_clear_pulse      = wdt_pulse_q;

  // ----------------------------------------------------------------
  // bus slave: read data caught in the setup cycle, zero wait states
  // ----------------------------------------------------------------
  logic [31:0] rd;
  logic        hit;
  always_comb begin
    rd  = '0;
    hit = 1'b1;
    case (paddr)
      OFS_CTRL:   rd = {31'h0, run_q};
      OFS_STATUS: rd = {25'h0, int_en_q, sleep_q, to_q, pd_q, dc_q, c_q, z_q};
      OFS_ACC:    rd = {24'h0, acc_q};
      OFS_PC:     rd = {19'h0, pc_q};
      OFS_CFG2:   rd = {17'h0, cfg2_q};
      OFS_CFG3:   rd = {17'h0, cfg3_q};
      OFS_CYCLES: rd = cycles_q;
      OFS_LAST:   rd = {30'h0, last_len_q};
      default: begin
        hit = reg_hit;
        rd  = reg_hit ? {24'h0, regs_q[apb_idx]} : 32'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= '0;
    else if (psel && !penable) prdata_q <= rd;
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_PC_WRITE_TWO: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && ex.wr_reg && f.reg_sel == PC_REG |=> (state_q == ST_FLUSH && !fetch_ready) [*2])
    else $error("counter write did not add a dead cycle");
  AST_JUMP_TARGET: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && ex.jump |=> pc_q == $past(ex.target) ##2 last_len_q == 2'd2)
    else $error("branch target or length wrong");
  AST_SKIP_ADV: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && ex.skip |-> ##3 pc_q == $past(pc_q, 3) + 13'd2)
    else $error("skipped word not stepped over");
  AST_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && !ex.jump && !ex.skip && !ex.to_long && !ex.slp
    |=> !fetch_ready ##1 fetch_ready)
    else $error("plain instruction not one cycle");
  AST_BIT_SET: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && f.major[6:3] == 4'b0101 && f.reg_sel != PC_REG
    |=> regs_q[$past(ridx)][$past(f.bit_sel)])
    else $error("bit set missed");
  AST_INTERRUPT_RETURN_OP: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && fetch_word == OP_INTERRUPT_RETURN_OP |=> int_en_q && pc_q == $past(top))
    else $error("interrupt return wrong");
  AST_DJZ: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && f.major == MJ_DJZ && f.reg_sel != PC_REG
    |=> regs_q[$past(ridx)] == $past(rval) - 8'h01 && $stable(z_q))
    else $error("decrement skip wrong");
  AST_DECREMENT_TO_ACC_SKIP_OP: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && f.major == MJ_DECREMENT_TO_ACC_SKIP_OP
    |=> acc_q == $past(rval) - 8'h01 && $stable(c_q) && $stable(z_q))
    else $error("decrement to accumulator wrong");
  AST_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && fetch_word == OP_SLEEP |=> sleep_pulse && wdt_clear_pulse && sleep_q && !pd_q)
    else $error("sleep effects missing");
  AST_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go && ex.wr_z |=> z_q == ($past(ex.res) == 8'h00))
    else $error("zero flag wrong");

endmodule : instruction_decode_timing

// >>> verification/prog_mem_model.sv
// program memory model feeding fetched words to the decoder
`timescale 1ns/1ps
module prog_mem_model
  import decode_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              slow,
  input  wire logic              ld_en,
  input  wire logic [PC_W-1:0]   ld_addr,
  input  wire logic [WORD_W-1:0] ld_word,
  input  wire logic [PC_W-1:0]   fetch_addr,
  output logic                   fetch_valid,
  output logic      [WORD_W-1:0] fetch_word
);
  logic [WORD_W-1:0] mem_q [0:255];
  logic [1:0]        gap_q;
  // ----------------------------------------
  // storage and a slow mode
  // ----------------------------------------
  // period of three so the stall slides across both clock phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_q <= 2'h0;
    else gap_q <= (gap_q == 2'h2) ? 2'h0 : gap_q + 2'h1;
  end
  always @(posedge pclk) begin
    if (ld_en) mem_q[ld_addr[7:0]] <= ld_word;
  end
  assign fetch_valid = !slow || (gap_q == 2'h2);
  // not valid: show the inverted word so stale data never looks good
  assign fetch_word  = fetch_valid ? mem_q[fetch_addr[7:0]] : ~mem_q[fetch_addr[7:0]];
endmodule : prog_mem_model

// >>> verification/tb_instruction_decode_timing.sv
// testbench for the instruction decode and timing block
`timescale 1ns/1ps
module tb_instruction_decode_timing
  import decode_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fetch_valid, fetch_ready;
  logic sleep_pulse, wdt_clear_pulse, touch_env_select, slow, ld_en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [PC_W-1:0] fetch_addr, ld_addr;
  logic [WORD_W-1:0] fetch_word, ld_word;
  logic [ID_W-1:0] customer_ident_field;
  int n_fail = 0, checks = 0, n_slp = 0, n_wdt = 0;
  // arbitrary customer id, non-zero so the field shows a pattern
  instruction_decode_timing #(.CUST_ID(6'h2a)) i_instruction_decode_timing (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .fetch_ready(fetch_ready), .sleep_pulse(sleep_pulse), .wdt_clear_pulse(wdt_clear_pulse),
    .touch_env_select(touch_env_select), .customer_ident_field(customer_ident_field));
  prog_mem_model i_prog_mem_model (.pclk(pclk), .presetn(presetn), .slow(slow), .ld_en(ld_en),
    .ld_addr(ld_addr), .ld_word(ld_word), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word));
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    n_slp <= n_slp + (sleep_pulse === 1'b1);
    n_wdt <= n_wdt + (wdt_clear_pulse === 1'b1);
  end
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(q, e);
  endtask : rd
  // poll until the core reports sleeping
  task automatic wait_sleep;
    for (int i = 0; i < 80; i++) begin
      apb(0, OFS_STATUS, 32'h0);
      if (q[5] === 1'b1) break;
    end
  endtask : wait_sleep
  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // tests
  // ----------------------------------------
  // run one: skips, bit set, jump, sleep; run two: call, literal return, counter write,
  // zero result, long call, interrupt return, sleep
  logic [PC_W-1:0]   pa [19] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 'h20, 'h21, 'h30, 'h22, 'h23, 'h28, 'h29,
                                 'h2a, 'h31, 'h2b};
  logic [WORD_W-1:0] pw [19] = '{'h6001, 'h0110, 'h1710, 'h6077, 'h2b10, 'h3b10, 'h6077, 'h1610,
                                 'h5020, 'h0003, 'h4030, 'h7028, 'h0004, 'h0102, 'h6800, 'h7a80,
                                 'h0031, 'h0013, 'h0003};
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ld_en, ld_addr, ld_word} = '0;
    presetn = 0; slow = 1;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rd(OFS_CFG2, 32'h3f7f); chk(touch_env_select, 1'b0);
    rd(OFS_CFG3, 32'h7fea); chk(customer_ident_field, 6'h2a);
    apb(1, OFS_CFG2, 32'h7f7f);
    rd(OFS_CFG2, 32'h7f7f);
    chk(touch_env_select, 1'b1);
    rd(12'h020, 32'h0); chk(err, 1'b1);
    $display("test reset values done");
    for (int i = 0; i < 19; i++) begin
      ld_en <= 1;
      ld_addr <= pa[i];
      ld_word <= pw[i];
      @(posedge pclk);
    end
    ld_en <= 0;
    apb(1, OFS_CTRL, 32'h1);
    wait_sleep;
    rd(OFS_CYCLES, 32'd11);
    rd(OFS_ACC, 32'h7);
    rd(12'h140, 32'h8);
    rd(OFS_PC, 32'h21);
    rd(OFS_LAST, 32'h1);
    rd(OFS_STATUS, 32'h30); chk(n_slp, 1); chk(n_wdt, 1);
    $display("test program slow memory done");
    slow <= 0;
    apb(1, OFS_CTRL, 32'h3); // wake and keep running
    wait_sleep;
    rd(OFS_CYCLES, 32'd24);
    rd(OFS_ACC, 32'h0);
    rd(OFS_PC, 32'h2c);
    rd(OFS_STATUS, 32'h71);
    chk(n_slp, 2);
    chk(n_wdt, 3);
    $display("test call and return done");
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    report_and_stop;
  end
endmodule : tb_instruction_decode_timing
